// *** rtl/pomc_pkg.sv ***
/*
 * constants for the process output mode control block: register map,
 * reset values, switch field positions and timing figures.
 * assumes a 40 MHz hclk.
 */
package pomc_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int MS_PER_S = 1000;
   // register byte offsets
   localparam logic [7:0] OFS_MISC = 8'h00;
   localparam logic [7:0] OFS_CYCLE = 8'h04;
   localparam logic [7:0] OFS_RATE = 8'h08;
   localparam logic [7:0] OFS_ERROR = 8'h0c;
   localparam logic [7:0] OFS_SETPT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_LOOP = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   // reset values
   localparam logic [7:0] RST_MISC = 8'hff;
   localparam logic [7:0] RST_CYCLE = 8'h04;
   localparam logic [5:0] RST_RATE = 6'h00;
   localparam logic [1:0] RST_IRQ_MASK = 2'h0;
   // misc function switch bit positions
   localparam int MF_SINGLE = 0;
   localparam int MF_AUTO = 1;
   localparam int MF_REVERSE = 2;
   localparam int MF_UNIT = 3;
   // cycle time switch value that selects the forced period
   localparam logic [7:0] CYCLE_LOOP_SETTING = 8'hff;
   localparam logic [7:0] FORCED_PERIOD_S = 8'h01;
   // demand scale: tenths of a percent
   localparam int DEMAND_FULL = 1000;
   // loop current in microamps
   localparam logic [14:0] LOOP_NULL_SINGLE = 15'd4000;
   localparam logic [18:0] LOOP_NULL_SPLIT = 19'd12000;
   // interrupt bits
   localparam int IRQ_PERIOD = 0;
   localparam int IRQ_CONFLICT = 1;
endpackage

// *** rtl/pomc_top.sv ***
/*
 * output-stage control: time-proportioned heat and cool relays and the
 * current loop level, configured and fed over an AHB-Lite slave.
 * assumes a single AHB master, one 40 MHz clock, and asynchronous pins
 * loop_fitted and linear_unit that are held static in use.
 */
// Added by the designer: the AHB-Lite register port and the address map.
// Functional notes
// - loop fitted and cycle switch 255: relay period forced to one second.
// - no loop fitted: period equals cycle switch seconds, 255 gives 255 s; switch 0 gives 1 s.
// - loop fitted, cycle switch not 255: raise loop conflict display flag.
// - single mode: 4 mA null, linear to 20 mA at full demand.
// - split mode: 12 mA null, 20 mA full heat, 4 mA full cool.
// - single reverse: +50 gives 12.0 mA, zero and negative give 4.0 mA.
// - split: +50 gives 16.0 mA, -50 gives 8.0 mA, extremes 20 and 4.
// - action bit high: reverse action, demand follows error sign.
// - action bit low: direct action, demand is negated error.
// - auto bit high: demand taken from process error feedback.
// - auto bit low: demand taken from setpoint value, same mapping.
// - temperature units: unit bit up means Celsius, down Fahrenheit.
// - linear units: unit bit low 4-20 mA input, high 0-500 mV.
// - misc switch positions five to eight have no effect.
// - cycle switch read as binary seconds, bit 1 least significant.
// - rate increase from bits 1-3, decrease 4-6; all zero disables rate.
// - reset gives single current, reverse action, automatic operation.
`timescale 1ns/1ps
module pomc_top
   import pomc_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // straps
   input wire logic loop_fitted,
   input wire logic linear_unit,
   // outputs to relays and loop
   output logic heat_relay,
   output logic cool_relay,
   output logic [14:0] loop_current_ua,
   // mode indications
   output logic loop_conflict,
   output logic temp_celsius,
   output logic input_mv_mode,
   output logic [2:0] rate_inc,
   output logic [2:0] rate_dec,
   output logic rate_enable,
   output logic irq
);

   typedef struct packed {
      logic wr_pend;
      logic [7:0] waddr;
      logic [31:0] rdata;
      logic [7:0] misc;
      logic [7:0] cyc;
      logic [5:0] rate;
      logic [15:0] err;
      logic [15:0] setpt;
      logic [1:0] ist;
      logic [1:0] imask;
      logic fit_m;
      logic fit;
      logic lin_m;
      logic lin;
      logic [15:0] ms_cnt;
      logic [17:0] el_ms;
      logic [7:0] per_s;
      logic [9:0] heat_duty;
      logic [9:0] cool_duty;
      logic heat_on;
      logic cool_on;
      logic [14:0] loop_ua;
      logic conflict;
   } pomc_state_t;

   pomc_state_t r;
   pomc_state_t next_r;

   logic signed [15:0] src_c;
   logic signed [15:0] d_c;
   logic signed [15:0] neg_c;
   logic [9:0] heat_c;
   logic [9:0] cool_c;
   logic [18:0] split_c;
   logic [7:0] per_sel_c;
   logic conflict_c;
   logic ms_tick_c;
   logic restart_c;
   logic addr_ok_c;
   logic [31:0] rmux_c;

   always_comb begin
      next_r = r;
      // pin synchronisers
      next_r.fit_m = loop_fitted;
      next_r.fit = r.fit_m;
      next_r.lin_m = linear_unit;
      next_r.lin = r.lin_m;

      // demand source and action
      src_c = r.misc[MF_AUTO] ? $signed(r.err) : $signed(r.setpt);
      if (r.misc[MF_REVERSE]) begin
         d_c = src_c;
      end else begin
         d_c = -src_c;
      end
      if (d_c > 16'sd1000) begin
         d_c = 16'(DEMAND_FULL);
      end else if (d_c < -16'sd1000) begin
         d_c = -16'(DEMAND_FULL);
      end
      neg_c = -d_c;
      heat_c = (d_c > 16'sd0) ? d_c[9:0] : 10'h000;
      cool_c = (d_c < 16'sd0) ? neg_c[9:0] : 10'h000;

      // loop current, bit 0 single or split; bits 4-7 unused
      split_c = LOOP_NULL_SPLIT + {d_c, 3'b000};
      if (r.misc[MF_SINGLE]) begin
         next_r.loop_ua = LOOP_NULL_SINGLE + {1'b0, heat_c, 4'h0};
      end else begin
         next_r.loop_ua = split_c[14:0];
      end

      // period selection, binary seconds
      conflict_c = r.fit && (r.cyc != CYCLE_LOOP_SETTING);
      next_r.conflict = conflict_c;
      if (r.fit && (r.cyc == CYCLE_LOOP_SETTING)) begin
         per_sel_c = FORCED_PERIOD_S;
      end else if (r.cyc == 8'h00) begin
         per_sel_c = FORCED_PERIOD_S;
      end else begin
         per_sel_c = r.cyc;
      end

      // millisecond divider and period timer
      ms_tick_c = (r.ms_cnt == 16'(MS_CYC - 1));
      next_r.ms_cnt = ms_tick_c ? 16'h0000 : r.ms_cnt + 16'h0001;
      restart_c = ms_tick_c && (r.el_ms >= 18'(r.per_s) * 18'(MS_PER_S) - 18'h00001);
      if (restart_c) begin
         next_r.el_ms = 18'h00000;
         next_r.per_s = per_sel_c;
         next_r.heat_duty = heat_c;
         next_r.cool_duty = cool_c;
      end else if (ms_tick_c) begin
         next_r.el_ms = r.el_ms + 18'h00001;
      end
      // relay on for duty/1000 of the period
      next_r.heat_on = !restart_c && (r.el_ms < 18'(r.heat_duty) * 18'(r.per_s));
      next_r.cool_on = !restart_c && (r.el_ms < 18'(r.cool_duty) * 18'(r.per_s));

      // sticky interrupt status, set wins over clear
      addr_ok_c = hsel && hready && htrans[1];
      if (r.wr_pend && r.waddr == OFS_IRQ_STAT) begin
         next_r.ist = r.ist & ~hwdata[1:0];
      end
      if (restart_c) begin
         next_r.ist[IRQ_PERIOD] = 1'b1;
      end
      if (conflict_c && !r.conflict) begin
         next_r.ist[IRQ_CONFLICT] = 1'b1;
      end

      // register writes in the data phase
      if (r.wr_pend) begin
         case (r.waddr)
            OFS_MISC: next_r.misc = hwdata[7:0];
            OFS_CYCLE: next_r.cyc = hwdata[7:0];
            OFS_RATE: next_r.rate = hwdata[5:0];
            OFS_ERROR: next_r.err = hwdata[15:0];
            OFS_SETPT: next_r.setpt = hwdata[15:0];
            OFS_IRQ_MASK: next_r.imask = hwdata[1:0];
            default: next_r.waddr = r.waddr;
         endcase
      end

      // read mux sampled in the address phase
      case (haddr[7:0])
         OFS_MISC: rmux_c = {24'h000000, r.misc};
         OFS_CYCLE: rmux_c = {24'h000000, r.cyc};
         OFS_RATE: rmux_c = {26'h0, r.rate};
         OFS_ERROR: rmux_c = {16'h0000, r.err};
         OFS_SETPT: rmux_c = {16'h0000, r.setpt};
         OFS_STATUS: rmux_c = {8'h00, r.per_s, 11'h000, r.lin, r.fit,
                               r.cool_on, r.heat_on, r.conflict};
         OFS_LOOP: rmux_c = {17'h0, r.loop_ua};
         OFS_IRQ_STAT: rmux_c = {30'h0, r.ist};
         OFS_IRQ_MASK: rmux_c = {30'h0, r.imask};
         default: rmux_c = 32'h00000000;
      endcase
      next_r.wr_pend = addr_ok_c && hwrite;
      if (addr_ok_c) begin
         next_r.waddr = haddr[7:0];
         if (!hwrite) begin
            next_r.rdata = rmux_c;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.misc <= RST_MISC;
         r.cyc <= RST_CYCLE;
         r.rate <= RST_RATE;
         r.imask <= RST_IRQ_MASK;
         r.per_s <= FORCED_PERIOD_S;
      end else begin
         r <= next_r;
      end
   end

   assign hrdata = r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign heat_relay = r.heat_on;
   assign cool_relay = r.cool_on;
   assign loop_current_ua = r.loop_ua;
   assign loop_conflict = r.conflict;
   assign temp_celsius = !r.lin && r.misc[MF_UNIT];
   assign input_mv_mode = r.lin && r.misc[MF_UNIT];
   assign rate_inc = r.rate[2:0];
   assign rate_dec = r.rate[5:3];
   assign rate_enable = |r.rate;
   assign irq = |(r.ist & r.imask);

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // period restart and the switch state seen with it
   sequence s_restart;
      restart_c;
   endsequence

   sequence s_loop_forced;
      s_restart ##0 (r.fit && r.cyc == 8'hff);
   endsequence

   sequence s_loop_absent;
      s_restart ##0 (!r.fit && r.cyc != 8'h00);
   endsequence

   sequence s_manual_single;
      !r.misc[1] && r.misc[2] && r.misc[0];
   endsequence

   sequence s_w1c_write;
      r.wr_pend && r.waddr == OFS_IRQ_STAT;
   endsequence

   a_forced_period: assert property (
      s_loop_forced |=> r.per_s == 8'h01)
      else $error("period not forced to one second");

   a_direct_period: assert property (
      s_loop_absent |=> r.per_s == $past(r.cyc))
      else $error("period differs from cycle switch");

   a_full_period: assert property (
      s_restart ##0 (!r.fit && r.cyc == 8'hff) |=> r.per_s == 8'hff)
      else $error("unfitted 255 setting not 255 seconds");

   a_binary_period: assert property (
      s_restart ##0 (!r.fit && r.cyc == 8'h02) |=> r.per_s == 8'h02)
      else $error("cycle switch not read as binary seconds");

   a_conflict_flag: assert property (
      (r.fit && r.cyc != 8'hff) |=> loop_conflict)
      else $error("loop conflict not shown");

   a_conflict_clear: assert property (
      (r.fit && r.cyc == 8'hff) |=> !loop_conflict)
      else $error("loop conflict shown with switch at 255");

   a_no_conflict: assert property (
      !r.fit |=> !loop_conflict)
      else $error("loop conflict shown without loop fitted");

   a_single_range: assert property (
      r.misc[0] |=> (loop_current_ua >= 15'd4000 && loop_current_ua <= 15'd20000))
      else $error("single current out of range");

   a_single_full: assert property (
      (r.misc[0] && d_c == 16'sd1000) |=> loop_current_ua == 15'd20000)
      else $error("single full demand not 20 mA");

   a_single_half: assert property (
      (r.misc[0] && d_c == 16'sd500) |=> loop_current_ua == 15'd12000)
      else $error("single half demand not 12 mA");

   a_single_clamp: assert property (
      (r.misc[0] && d_c <= 16'sd0) |=> loop_current_ua == 15'd4000)
      else $error("single null not 4 mA");

   a_split_full: assert property (
      (!r.misc[0] && d_c == 16'sd1000) |=> loop_current_ua == 15'd20000)
      else $error("split full heat not 20 mA");

   a_split_null: assert property (
      (!r.misc[0] && d_c == 16'sd0) |=> loop_current_ua == 15'd12000)
      else $error("split null not 12 mA");

   a_split_range: assert property (
      !r.misc[0] |=> (loop_current_ua >= 15'd4000 && loop_current_ua <= 15'd20000))
      else $error("split current out of range");

   a_split_heat: assert property (
      (!r.misc[0] && d_c == 16'sd500) |=> loop_current_ua == 15'd16000)
      else $error("split half heat not 16 mA");

   a_split_cool: assert property (
      (!r.misc[0] && d_c == -16'sd500) |=> loop_current_ua == 15'd8000)
      else $error("split half cool not 8 mA");

   a_split_empty: assert property (
      (!r.misc[0] && d_c == -16'sd1000) |=> loop_current_ua == 15'd4000)
      else $error("split full cool not 4 mA");

   a_reverse_sign: assert property (
      (r.misc[2] && src_c == 16'sd500) |-> d_c == 16'sd500)
      else $error("reverse action sign wrong");

   a_action_sign: assert property (
      (!r.misc[2] && src_c == 16'sd500) |-> d_c == -16'sd500)
      else $error("direct action sign wrong");

   a_auto_source: assert property (
      (r.misc[1] && r.misc[2] && $signed(r.err) == 16'sd500) |-> d_c == 16'sd500)
      else $error("automatic demand not from error");

   a_manual_source: assert property (
      (s_manual_single ##0 r.setpt == 16'd200) |=> loop_current_ua == 15'd7200)
      else $error("manual demand not from setpoint");

   a_rate_off: assert property (
      (r.rate == 6'h00) |-> !rate_enable)
      else $error("rate enabled with all bits down");

   a_relay_idle: assert property (
      s_restart ##0 (heat_c == 10'h000) |=> ##1 !heat_relay [*8])
      else $error("heat relay on at zero duty");

   a_relay_restart: assert property (
      s_restart |=> (!heat_relay && !cool_relay))
      else $error("relay not low at period restart");

   a_relay_exclusive: assert property (
      !(heat_relay && cool_relay))
      else $error("heat and cool relays on together");

   a_period_irq: assert property (
      s_restart |=> r.ist[IRQ_PERIOD])
      else $error("period start status not set");

   a_set_wins: assert property (
      (s_w1c_write ##0 restart_c) |=> r.ist[IRQ_PERIOD])
      else $error("status clear beat a same cycle set");

   a_ready_high: assert property (
      hreadyout)
      else $error("slave inserted a wait state");

   a_okay_resp: assert property (
      !hresp)
      else $error("slave response not okay");

endmodule

// *** verif/pomc_relay_load.sv ***
/*
 * heat and cool relay load: measures the length of each on pulse.
 * assumes relay outputs are levels sampled on the rising hclk edge.
 */
`timescale 1ns/1ps
module pomc_relay_load (
   // clock
   input wire logic hclk,
   // relay drive
   input wire logic heat_relay,
   input wire logic cool_relay,
   // measured on lengths in cycles
   output logic [31:0] heat_len,
   output logic [31:0] cool_len
);
   logic [31:0] h_run;
   logic [31:0] c_run;
   initial begin
      heat_len = 0;
      cool_len = 0;
      h_run = 0;
      c_run = 0;
   end
   // on time of each relay pulse, latched when it ends
   always @(posedge hclk) begin
      if (heat_relay === 1'b1) h_run <= h_run + 1;
      else begin
         if (h_run != 0) heat_len <= h_run;
         h_run <= 0;
      end
      if (cool_relay === 1'b1) c_run <= c_run + 1;
      else begin
         if (c_run != 0) cool_len <= c_run;
         c_run <= 0;
      end
   end
endmodule

// *** verif/pomc_top_tb.sv ***
/*
 * self-checking bench for pomc_top over AHB-Lite.
 * assumes zero wait state slave and MS_CYC of 4 cycles per ms.
 */
`timescale 1ns/1ps
module pomc_top_tb;
   import pomc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, loop_fitted, linear_unit;
   logic [31:0] haddr, hwdata, hrdata, rd, got, e, heat_len, cool_len;
   logic [1:0] htrans;
   logic hreadyout, hresp, heat_relay, cool_relay, loop_conflict;
   logic temp_celsius, input_mv_mode, rate_enable, irq;
   logic [14:0] loop_current_ua;
   logic [2:0] rate_inc, rate_dec;
   logic [31:0] exp_q[$];
   int bad_count, check_count, cyc, ev;
   event got_ev;
   pomc_top #(.MS_CYC(4)) u_pomc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .loop_fitted(loop_fitted), .linear_unit(linear_unit), .heat_relay(heat_relay),
      .cool_relay(cool_relay), .loop_current_ua(loop_current_ua),
      .loop_conflict(loop_conflict), .temp_celsius(temp_celsius),
      .input_mv_mode(input_mv_mode), .rate_inc(rate_inc), .rate_dec(rate_dec),
      .rate_enable(rate_enable), .irq(irq));
   pomc_relay_load u_pomc_relay_load (.hclk(hclk), .heat_relay(heat_relay),
      .cool_relay(cool_relay), .heat_len(heat_len), .cool_len(cool_len));
   initial begin
      hclk = 0;
      forever #12.5 hclk = ~hclk;
   end
   task test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 95000) begin
         bad_count++;
         $display("Error at %0t: timeout", $time);
         test_done;
      end
   end
   // watcher: oldest expectation against each observed result
   initial forever begin
      @(got_ev);
      e = exp_q.pop_front();
      check_count++;
      if (got !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   end
   task chk(input logic [31:0] a, input logic [31:0] x);
      exp_q.push_back(x);
      got = a;
      ->got_ev;
      #1;
   endtask
   task settle(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] x);
      bus(0, a, 32'h0);
      chk(rd, x);
   endtask
   task wait_per(input logic [7:0] p);
      int n;
      n = 0;
      do begin
         settle(100);
         bus(0, OFS_STATUS, 32'h0);
         n++;
      end while (rd[23:16] !== p && n < 400);
      chk({24'h0, rd[23:16]}, {24'h0, p});
   endtask
   function automatic int lp(input bit sgl, input int d);
      return sgl ? 4000 + 16 * (d > 0 ? d : 0) : 12000 + 8 * d;
   endfunction
   initial begin
      hresetn = 0;
      hsel = 0;
      haddr = 0;
      htrans = 0;
      hwrite = 0;
      hwdata = 0;
      loop_fitted = 0;
      linear_unit = 0;
      void'($urandom(32'hc1b2dce8));
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      rdc(OFS_MISC, 32'hff);
      rdc(OFS_CYCLE, 32'h04);
      rdc(OFS_RATE, 32'h0);
      rdc(8'h40, 32'h0);
      rdc(OFS_LOOP, 32'd4000);
      chk(temp_celsius, 1);
      $display("reset test done");
      for (int k = 0; k < 2; k++) begin
         wr(OFS_MISC, k ? 32'hfe : 32'hff);
         for (int i = 0; i < 5; i++) begin
            ev = 1000 - 500 * i;
            wr(OFS_ERROR, 32'(ev));
            settle(3);
            chk({17'h0, loop_current_ua}, 32'(lp(k == 0, ev)));
            rdc(OFS_LOOP, 32'(lp(k == 0, ev)));
         end
      end
      repeat (8) begin
         ev = int'($urandom_range(2000)) - 1000;
         wr(OFS_ERROR, 32'(ev));
         settle(3);
         chk({17'h0, loop_current_ua}, 32'(lp(0, ev)));
      end
      wr(OFS_MISC, 32'hfa);
      wr(OFS_ERROR, 32'd500);
      rdc(OFS_LOOP, 32'd8000);
      wr(OFS_MISC, 32'hfd);
      wr(OFS_ERROR, 32'h0);
      wr(OFS_SETPT, 32'd200);
      rdc(OFS_LOOP, 32'd7200);
      wr(OFS_SETPT, 32'd500);
      rdc(OFS_LOOP, 32'd12000);
      wr(OFS_MISC, 32'h0f);
      wr(OFS_ERROR, 32'd500);
      rdc(OFS_LOOP, 32'd12000);
      $display("loop test done");
      chk(temp_celsius, 1);
      wr(OFS_MISC, 32'h07);
      settle(2);
      chk(temp_celsius, 0);
      @(posedge hclk);
      linear_unit <= 1;
      settle(4);
      chk(input_mv_mode, 0);
      wr(OFS_MISC, 32'hff);
      settle(2);
      chk({input_mv_mode, temp_celsius}, 2'b10);
      wr(OFS_RATE, 32'h2c);
      settle(2);
      chk({rate_enable, rate_dec, rate_inc}, 7'b1101100);
      wr(OFS_RATE, 32'h0);
      settle(2);
      chk(rate_enable, 0);
      $display("mode test done");
      @(posedge hclk);
      linear_unit <= 0;
      loop_fitted <= 1;
      wr(OFS_IRQ_MASK, 32'h2);
      settle(5);
      chk({loop_conflict, irq}, 2'b11);
      wr(OFS_IRQ_STAT, 32'h2);
      settle(2);
      chk(irq, 0);
      wait_per(8'h04);
      wr(OFS_CYCLE, 32'hff);
      settle(5);
      chk(loop_conflict, 0);
      wait_per(8'h01);
      @(posedge hclk);
      loop_fitted <= 0;
      wr(OFS_CYCLE, 32'h02);
      wait_per(8'h02);
      wr(OFS_CYCLE, 32'h01);
      wait_per(8'h01);
      $display("period test done");
      settle(9000);
      chk(heat_len >= 1996 && heat_len <= 2000, 1);
      chk(cool_len, 0);
      wr(OFS_ERROR, -32'd250);
      settle(9000);
      chk(cool_len >= 996 && cool_len <= 1000, 1);
      $display("relay test done");
      test_done;
   end
endmodule
